// >>> memcfg_pkg.sv
// Package with register map, field positions, reset values and timing for the memory interface configuration block
// Operation
// - Clock tri-state bit floats memory clock while bus grant is active.
// - Byte masks driven high after power-down until first SDRAM access, unless disabled.
// - With idle power-down on, clock enable drops after seven idle SDRAM cycles.
// - Debug show bit puts internal register accesses onto pins with a strobe.
// - Each address remapper is active only when its own enable bit is set.
// - Write-in-page request keeps page mode only when write-in-page is enabled.
// - Static selects three, two, one decode in user space only when enabled.
// - Select-one-in-bank bit enables static select one inside bank space.
// - Bank type codes: 11 x16 SDRAM, 10 x8 SDRAM, 01 x32 DRAM, 00 x16 DRAM.
// - Row and column map fields choose address bits driven on the 13 pins.
// - Size bit set makes a static select 32-bit, clear makes it 16-bit.
// - Select-zero size bit loads from the test strap level on the first enabled clock edge after reset release.
// - Page reads use first timing then burst timing for three; writes use first.
// - Each select's page enable bit turns on read page bursts for it.
package memcfg_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [11:0] OFS_BANK_SETUP = 12'h0000;
    localparam logic [11:0] OFS_MEMSEL_TIMING = 12'h0004;
    localparam logic [11:0] OFS_STATIC_TIMING = 12'h0008;
    localparam logic [11:0] OFS_CARD_TIMING = 12'h000c;
    localparam logic [11:0] OFS_STATUS = 12'h0010;

    // ----------------------------------------
    // Bank setup and card timing field positions
    // ----------------------------------------
    localparam int CLOCK_FLOAT_BIT = 30;
    localparam int BYTE_MASK_INIT_DIS_BIT = 29;
    localparam int SDRAM_PD_EN_BIT = 28;
    localparam int DEBUG_SHOW_BIT = 27;
    localparam int REMAP_TWO_BIT = 26;
    localparam int REMAP_ONE_BIT = 25;
    localparam int WRITE_IN_PAGE_BIT = 24;
    localparam int SEL3_USER_BIT = 23;
    localparam int SEL2_USER_BIT = 22;
    localparam int SEL1_USER_BIT = 21;
    localparam int SEL1_BANK_BIT = 20;
    localparam int BANK1_TYPE_LSB = 18;
    localparam int BANK0_TYPE_LSB = 16;
    localparam int BANK1_ROW_LSB = 14;
    localparam int BANK0_ROW_LSB = 12;
    localparam int BANK1_COL_LSB = 8;
    localparam int BANK0_COL_LSB = 4;
    localparam int SEL0_WIDE_BIT = 0;
    localparam int CARD_PAGE_LSB = 8;

    // ----------------------------------------
    // Reset values and masks
    // ----------------------------------------
    localparam logic [31:0] BANK_SETUP_RESET = 32'h0000_0000;
    localparam logic [31:0] BANK_SETUP_MASK = 32'h7fff_ffff;
    localparam logic [31:0] STATIC_TIMING_RESET = 32'h0000_00ff;
    localparam logic [31:0] CARD_TIMING_RESET = 32'h0000_0000;
    localparam logic [31:0] CARD_TIMING_MASK = 32'hffff_fff8;
    localparam logic [31:0] MEMSEL_TIMING_RESET = 32'h0000_0000;

    // ----------------------------------------
    // Bank type codes
    // ----------------------------------------
    localparam logic [1:0] TYPE_SDRAM16 = 2'h3;
    localparam logic [1:0] TYPE_SDRAM8 = 2'h2;
    localparam logic [1:0] TYPE_DRAM32 = 2'h1;
    localparam logic [1:0] TYPE_DRAM16 = 2'h0;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam logic [2:0] SDRAM_IDLE_LIMIT = 3'h7;
    localparam logic [1:0] BURST_FOLLOW_COUNT = 2'h3;

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b00,
        ACC_WAIT = 2'b01,
        ACC_DONE = 2'b10
    } acc_state_t;

endpackage : memcfg_pkg

// >>> memory_interface_config.sv
// Memory interface configuration register bank and its controlled behaviour
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module memory_interface_config (
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic test_strap_pin,
    input wire logic bus_grant_n,
    input wire logic memory_clock_in,
    output logic memory_clock_out,
    output logic memory_clock_out_oe,
    input wire logic powerdown_exit,
    input wire logic sdram_access,
    output logic sdram_clock_enable,
    output logic upper_byte_mask,
    output logic lower_byte_mask,
    input wire logic internal_access,
    input wire logic internal_is_read,
    input wire logic [12:0] internal_addr,
    input wire logic [31:0] internal_data,
    output logic debug_read_n,
    output logic [12:0] debug_addr,
    output logic [31:0] debug_data,
    output logic debug_drive_oe,
    output logic register_strobe_n,
    input wire logic [1:0] bank_addr_sel,
    input wire logic col_phase,
    input wire logic [24:0] mem_addr,
    output logic [12:0] mux_addr,
    output logic [1:0] bank_type,
    output logic bank_is_sdram,
    input wire logic remap_two_hit,
    input wire logic remap_one_hit,
    output logic remap_two_active,
    output logic remap_one_active,
    input wire logic write_in_page,
    output logic hold_page,
    input wire logic user_mode,
    input wire logic [3:1] static_decode,
    input wire logic bank_space,
    output logic [3:0] static_sel_en,
    output logic [3:0] static_wide,
    input wire logic acc_start,
    input wire logic acc_is_memsel,
    input wire logic [1:0] acc_sel,
    input wire logic acc_is_read,
    input wire logic acc_burst,
    output logic acc_busy,
    output logic acc_done,
    output logic [3:0] acc_time_used,
    output logic acc_page_mode
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] bank_setup;
        logic [31:0] memsel_timing;
        logic [31:0] static_timing;
        logic [31:0] card_timing;
        logic strap_taken;
        logic [31:0] rdata;
        logic [2:0] idle_cnt;
        logic cke;
        logic mask_high;
        logic dbg_strobe_n;
        logic dbg_oe;
        logic dbg_read_n;
        logic [12:0] dbg_addr;
        logic [31:0] dbg_data;
        memcfg_pkg::acc_state_t acc_state;
        logic [3:0] acc_cnt;
        logic [1:0] beats_left;
        logic acc_memsel;
        logic [1:0] acc_sel;
        logic acc_read;
        logic acc_page;
        logic [3:0] time_used;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    logic [3:0] page_bits;
    logic [3:0] first_time;
    logic [3:0] burst_time;
    logic [31:0] timing_word;
    logic [1:0] row_map;
    logic [3:0] col_map;
    logic [12:0] row_addr;
    logic [12:0] col_addr;
    logic [24:0] a;

    always_comb
    begin
        timing_word = acc_is_memsel ? state_reg.memsel_timing : state_reg.static_timing;
        first_time = timing_word[{acc_sel, 3'h7} -: 4];
        burst_time = timing_word[{acc_sel, 3'h3} -: 4];
        page_bits = acc_is_memsel ? state_reg.card_timing[memcfg_pkg::CARD_PAGE_LSB + 4 +: 4]
                                  : state_reg.card_timing[memcfg_pkg::CARD_PAGE_LSB +: 4];
    end

    // Row and column multiplexing per bank
    always_comb
    begin
        a = mem_addr;
        if (bank_addr_sel[0])
        begin
            row_map = state_reg.bank_setup[memcfg_pkg::BANK1_ROW_LSB +: 2];
            col_map = state_reg.bank_setup[memcfg_pkg::BANK1_COL_LSB +: 4];
        end
        else
        begin
            row_map = state_reg.bank_setup[memcfg_pkg::BANK0_ROW_LSB +: 2];
            col_map = state_reg.bank_setup[memcfg_pkg::BANK0_COL_LSB +: 4];
        end
        case (row_map)
            2'h0: row_addr = {3'h0, a[18], a[17:9]};
            2'h1: row_addr = {a[22], a[18], a[20], a[19], a[17:9]};
            2'h2: row_addr = {a[20], a[22], a[21], a[19], a[17:9]};
            default: row_addr = {a[22], a[23], a[21], a[19], a[17:9]};
        endcase
        case (col_map)
            4'h0: col_addr = {2'h0, a[22], a[20], a[18], a[8:1]};
            4'h1: col_addr = {4'h0, a[19], a[18], a[8:2]};
            4'h2: col_addr = {3'h0, a[21], a[20], a[18], a[8:2]};
            4'h3: col_addr = {2'h0, a[23], a[22], a[20], a[18], a[8:2]};
            4'h4: col_addr = {2'h0, a[24], a[22], a[20], a[18], a[8:2]};
            4'h5: col_addr = {1'b0, a[18], 2'h0, a[8:0]};
            4'h6: col_addr = {a[22], 2'h0, a[21], a[8:0]};
            4'h7: col_addr = {1'b0, a[18], 2'h0, a[21], a[8:1]};
            4'h8: col_addr = {a[22], 2'h0, a[23], a[21], a[8:1]};
            4'h9: col_addr = {3'h0, a[24], a[23], a[21], a[8:2]};
            default: col_addr = 13'h0000;
        endcase
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        state_next = state_reg;
        // Register writes
        if (reg_write)
        begin
            case (reg_addr)
                memcfg_pkg::OFS_BANK_SETUP:
                    state_next.bank_setup = reg_wdata & memcfg_pkg::BANK_SETUP_MASK;
                memcfg_pkg::OFS_MEMSEL_TIMING: state_next.memsel_timing = reg_wdata;
                memcfg_pkg::OFS_STATIC_TIMING: state_next.static_timing = reg_wdata;
                memcfg_pkg::OFS_CARD_TIMING:
                    state_next.card_timing = reg_wdata & memcfg_pkg::CARD_TIMING_MASK;
                default: ;
            endcase
        end
        // Strap captured on first enabled edge after reset release
        if (!state_reg.strap_taken)
        begin
            state_next.strap_taken = 1'b1;
            state_next.bank_setup[memcfg_pkg::SEL0_WIDE_BIT] = test_strap_pin;
        end
        // Register reads, data valid the following cycle
        state_next.rdata = 32'h0000_0000;
        if (reg_read)
        begin
            case (reg_addr)
                memcfg_pkg::OFS_BANK_SETUP: state_next.rdata = state_reg.bank_setup;
                memcfg_pkg::OFS_MEMSEL_TIMING: state_next.rdata = state_reg.memsel_timing;
                memcfg_pkg::OFS_STATIC_TIMING: state_next.rdata = state_reg.static_timing;
                memcfg_pkg::OFS_CARD_TIMING: state_next.rdata = state_reg.card_timing;
                memcfg_pkg::OFS_STATUS:
                    state_next.rdata = {22'h00_0000, state_reg.acc_page, state_reg.acc_state,
                                        state_reg.mask_high, state_reg.cke, 1'b0, state_reg.time_used};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        // SDRAM idle power-down
        if (sdram_access)
        begin
            state_next.idle_cnt = 3'h0;
            state_next.cke = 1'b1;
        end
        else if (state_reg.bank_setup[memcfg_pkg::SDRAM_PD_EN_BIT])
        begin
            if (state_reg.idle_cnt == memcfg_pkg::SDRAM_IDLE_LIMIT - 3'h1)
                state_next.cke = 1'b0;
            if (state_reg.idle_cnt != memcfg_pkg::SDRAM_IDLE_LIMIT)
                state_next.idle_cnt = state_reg.idle_cnt + 3'h1;
        end
        else
        begin
            state_next.idle_cnt = 3'h0;
            state_next.cke = 1'b1;
        end
        // Byte masks after power-down exit; access clears, exit sets unless the init-disable bit is set
        if (sdram_access)
            state_next.mask_high = 1'b0;
        if (powerdown_exit)
            state_next.mask_high = !state_reg.bank_setup[memcfg_pkg::BYTE_MASK_INIT_DIS_BIT];
        // Debug show of internal register accesses
        state_next.dbg_strobe_n = 1'b1;
        state_next.dbg_oe = 1'b0;
        if (state_reg.bank_setup[memcfg_pkg::DEBUG_SHOW_BIT] && internal_access)
        begin
            state_next.dbg_oe = 1'b1;
            state_next.dbg_strobe_n = 1'b0;
            state_next.dbg_read_n = !internal_is_read;
            state_next.dbg_addr = internal_addr;
            state_next.dbg_data = internal_data;
        end
        // Access timing sequencer
        state_next.time_used = state_reg.time_used;
        case (state_reg.acc_state)
            memcfg_pkg::ACC_IDLE:
                if (acc_start)
                begin
                    state_next.acc_state = memcfg_pkg::ACC_WAIT;
                    state_next.acc_memsel = acc_is_memsel;
                    state_next.acc_sel = acc_sel;
                    state_next.acc_read = acc_is_read;
                    state_next.acc_page = page_bits[acc_sel] && acc_is_read && acc_burst;
                    state_next.beats_left = memcfg_pkg::BURST_FOLLOW_COUNT;
                    state_next.acc_cnt = first_time;
                    state_next.time_used = first_time;
                end
            memcfg_pkg::ACC_WAIT:
                if (state_reg.acc_cnt == 4'h0)
                    state_next.acc_state = memcfg_pkg::ACC_DONE;
                else
                    state_next.acc_cnt = state_reg.acc_cnt - 4'h1;
            memcfg_pkg::ACC_DONE:
                if (state_reg.acc_page && state_reg.beats_left != 2'h0)
                begin
                    state_next.acc_state = memcfg_pkg::ACC_WAIT;
                    state_next.beats_left = state_reg.beats_left - 2'h1;
                    state_next.acc_cnt = state_reg.acc_memsel
                        ? state_reg.memsel_timing[{state_reg.acc_sel, 3'h3} -: 4]
                        : state_reg.static_timing[{state_reg.acc_sel, 3'h3} -: 4];
                    state_next.time_used = state_next.acc_cnt;
                end
                else
                    state_next.acc_state = memcfg_pkg::ACC_IDLE;
            default: state_next.acc_state = memcfg_pkg::ACC_IDLE;
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= '0;
            state_reg.bank_setup <= memcfg_pkg::BANK_SETUP_RESET;
            state_reg.memsel_timing <= memcfg_pkg::MEMSEL_TIMING_RESET;
            state_reg.static_timing <= memcfg_pkg::STATIC_TIMING_RESET;
            state_reg.card_timing <= memcfg_pkg::CARD_TIMING_RESET;
            state_reg.cke <= 1'b1;
            state_reg.dbg_strobe_n <= 1'b1;
            state_reg.dbg_read_n <= 1'b1;
            state_reg.acc_state <= memcfg_pkg::ACC_IDLE;
        end
        else if (clk_en)
            state_reg <= state_next;
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic [3:0] user_ok;

    always_comb
    begin
        reg_rdata = state_reg.rdata;
        memory_clock_out = memory_clock_in;
        memory_clock_out_oe = !(state_reg.bank_setup[memcfg_pkg::CLOCK_FLOAT_BIT] && !bus_grant_n);
        sdram_clock_enable = state_reg.cke;
        upper_byte_mask = state_reg.mask_high;
        lower_byte_mask = state_reg.mask_high;
        debug_read_n = state_reg.dbg_read_n;
        debug_addr = state_reg.dbg_addr;
        debug_data = state_reg.dbg_data;
        debug_drive_oe = state_reg.dbg_oe;
        register_strobe_n = state_reg.dbg_strobe_n;
        mux_addr = col_phase ? col_addr : row_addr;
        bank_type = bank_addr_sel[0] ? state_reg.bank_setup[memcfg_pkg::BANK1_TYPE_LSB +: 2]
                                     : state_reg.bank_setup[memcfg_pkg::BANK0_TYPE_LSB +: 2];
        bank_is_sdram = (bank_type == memcfg_pkg::TYPE_SDRAM16) || (bank_type == memcfg_pkg::TYPE_SDRAM8);
        remap_two_active = remap_two_hit && state_reg.bank_setup[memcfg_pkg::REMAP_TWO_BIT];
        remap_one_active = remap_one_hit && state_reg.bank_setup[memcfg_pkg::REMAP_ONE_BIT];
        hold_page = write_in_page && state_reg.bank_setup[memcfg_pkg::WRITE_IN_PAGE_BIT];
        user_ok = {state_reg.bank_setup[memcfg_pkg::SEL3_USER_BIT], state_reg.bank_setup[memcfg_pkg::SEL2_USER_BIT],
                   state_reg.bank_setup[memcfg_pkg::SEL1_USER_BIT], 1'b1};
        static_sel_en[0] = 1'b0;
        static_sel_en[3:1] = static_decode & (user_mode ? user_ok[3:1] : 3'h7);
        if (bank_space && state_reg.bank_setup[memcfg_pkg::SEL1_BANK_BIT])
            static_sel_en[1] = 1'b1;
        static_wide = state_reg.bank_setup[3:0];
        acc_busy = state_reg.acc_state != memcfg_pkg::ACC_IDLE;
        acc_done = state_reg.acc_state == memcfg_pkg::ACC_DONE;
        acc_time_used = state_reg.time_used;
        acc_page_mode = state_reg.acc_page;
    end

endmodule : memory_interface_config

// >>> memcfg_assertions.sv
// Checker for the memory interface configuration block
`timescale 1ns/1ps
module memcfg_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic bus_grant_n,
    input wire logic memory_clock_out_oe,
    input wire logic sdram_access,
    input wire logic sdram_clock_enable,
    input wire logic powerdown_exit,
    input wire logic upper_byte_mask,
    input wire logic lower_byte_mask,
    input wire logic internal_access,
    input wire logic register_strobe_n,
    input wire logic remap_two_hit,
    input wire logic remap_one_hit,
    input wire logic remap_two_active,
    input wire logic remap_one_active,
    input wire logic write_in_page,
    input wire logic hold_page
);
    logic [31:0] cfg_reg;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Copy of the bank setup word as software wrote it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cfg_reg <= 32'h0000_0000;
        else if (reg_write && reg_addr == memcfg_pkg::OFS_BANK_SETUP)
            cfg_reg <= reg_wdata;
    end
    sequence idle_run;
        !sdram_access [*7];
    endsequence
    sequence strobe_pulse;
        !register_strobe_n ##1 register_strobe_n;
    endsequence
    AST_CLK_FLOAT: assert property (memory_clock_out_oe == !(cfg_reg[30] && !bus_grant_n))
        else $error("memory clock drive enable wrong");
    AST_PD_DROP: assert property (cfg_reg[28] throughout idle_run |=> !sdram_clock_enable)
        else $error("clock enable high after seven idle cycles");
    AST_PD_WAKE: assert property (sdram_access |=> sdram_clock_enable)
        else $error("clock enable low after access");
    AST_MASK_HIGH: assert property (powerdown_exit && !cfg_reg[29] |=> upper_byte_mask && lower_byte_mask)
        else $error("byte masks not high after power-down exit");
    AST_MASK_CLR: assert property (sdram_access && !powerdown_exit |=> !upper_byte_mask && !lower_byte_mask)
        else $error("byte masks not low after access");
    AST_DEBUG_SHOW: assert property (internal_access && cfg_reg[27] |=> strobe_pulse)
        else $error("register strobe pulse missing");
    AST_REMAP: assert property ((remap_two_active == (remap_two_hit && cfg_reg[26]))
        && (remap_one_active == (remap_one_hit && cfg_reg[25])))
        else $error("remapper activity wrong");
    AST_PAGE: assert property (hold_page == (write_in_page && cfg_reg[24]))
        else $error("page hold wrong");
endmodule : memcfg_checker

bind memory_interface_config memcfg_checker u_memcfg_checker (.*);

// >>> memory_partner.sv
// External memory model giving the memory clock and SDRAM access traffic
`timescale 1ns/1ps
module memory_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic want,
    output logic memory_clock_in,
    output logic sdram_access
);
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            memory_clock_in <= 1'b0;
        else
            memory_clock_in <= !memory_clock_in;
    end
    assign sdram_access = want;
endmodule : memory_partner

// >>> tb_memory_interface_config.sv
// Self-checking testbench for the memory interface configuration block
`timescale 1ns/1ps
module tb_memory_interface_config;
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, bus_grant_n = 1'b1, pd_exit = 1'b0;
    logic want = 1'b0, internal_access = 1'b0, internal_is_read = 1'b0, col_phase = 1'b0, user_mode = 1'b0;
    logic remap_two_hit = 1'b0, remap_one_hit = 1'b0, write_in_page = 1'b0, bank_space = 1'b0;
    logic acc_start = 1'b0, acc_is_read = 1'b0, acc_burst = 1'b0, test_strap_pin = 1'b1;
    logic [1:0] bank_addr_sel = 2'h0, bank_type;
    logic [2:0] static_decode = 3'h0;
    logic [11:0] reg_addr = 12'h000;
    logic [12:0] internal_addr = 13'h0000, debug_addr, mux_addr;
    logic [24:0] mem_addr = 25'h1ff_ffff;
    logic [31:0] reg_wdata = 32'h0000_0000, internal_data = 32'h0000_0000, reg_rdata, debug_data;
    logic [3:0] static_sel_en, static_wide, acc_time_used;
    logic memory_clock_in, memory_clock_out, memory_clock_out_oe, sdram_access, sdram_clock_enable;
    logic upper_byte_mask, lower_byte_mask, debug_read_n, debug_drive_oe, register_strobe_n, bank_is_sdram;
    logic remap_two_active, remap_one_active, hold_page, acc_busy, acc_done, acc_page_mode;
    int failures = 0;
    int cmp_count = 0;
    memory_interface_config u_memory_interface_config (.clk_en(1'b1),
        .acc_is_memsel(1'b1), .acc_sel(2'h0), .powerdown_exit(pd_exit), .*);
    memory_partner u_memory_partner (.clk(clk), .rst(rst), .want(want), .memory_clock_in(memory_clock_in),
        .sdram_access(sdram_access));
    always #10 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic wr_cfg(input logic [31:0] d);
        wr(memcfg_pkg::OFS_BANK_SETUP, d);
    endtask : wr_cfg
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd_chk
    task automatic t_regs;
        rd_chk(memcfg_pkg::OFS_BANK_SETUP, 32'h0000_0001);
        chk(32'(static_wide), 32'h0000_0001);
        rd_chk(memcfg_pkg::OFS_MEMSEL_TIMING, memcfg_pkg::MEMSEL_TIMING_RESET);
        rd_chk(memcfg_pkg::OFS_STATIC_TIMING, memcfg_pkg::STATIC_TIMING_RESET);
        wr(12'h020, 32'hffff_ffff);
        rd_chk(12'h020, 32'h0000_0000);
        wr(memcfg_pkg::OFS_CARD_TIMING, 32'hffff_ffff);
        rd_chk(memcfg_pkg::OFS_CARD_TIMING, memcfg_pkg::CARD_TIMING_MASK);
        wr_cfg(32'hffff_ffff);
        rd_chk(memcfg_pkg::OFS_BANK_SETUP, memcfg_pkg::BANK_SETUP_MASK);
    endtask : t_regs
    task automatic t_clock;
        logic [31:0] cf [3] = '{32'h4000_0000, 32'h4000_0000, 32'h0000_0000};
        logic g [3] = '{1'b0, 1'b1, 1'b0};
        foreach (cf[i])
        begin
            wr_cfg(cf[i]);
            @(posedge clk);
            bus_grant_n <= g[i];
            #1;
            chk(32'(memory_clock_out_oe), 32'(g[i] || !cf[i][30]));
            chk(32'(memory_clock_out), 32'(memory_clock_in));
        end
        bus_grant_n <= 1'b1;
    endtask : t_clock
    task automatic pulse_exit(input logic [31:0] e);
        @(posedge clk);
        pd_exit <= 1'b1;
        @(posedge clk);
        pd_exit <= 1'b0;
        #1;
        chk(32'({upper_byte_mask, lower_byte_mask}), e);
    endtask : pulse_exit
    task automatic t_power;
        wr_cfg(32'h1000_0000);
        repeat (6) @(posedge clk);
        #1;
        chk(32'(sdram_clock_enable), 32'h0000_0001);
        @(posedge clk);
        #1;
        chk(32'(sdram_clock_enable), 32'h0000_0000);
        pulse_exit(32'h0000_0003);
        rd_chk(memcfg_pkg::OFS_STATUS, 32'h0000_0040);
        repeat (3) @(posedge clk);
        want <= 1'b1;
        @(posedge clk);
        want <= 1'b0;
        #1;
        chk(32'({sdram_clock_enable, upper_byte_mask, lower_byte_mask}), 32'h0000_0004);
        pulse_exit(32'h0000_0003);
        wr_cfg(32'h2000_0000);
        pulse_exit(32'h0000_0000);
    endtask : t_power
    task automatic t_debug;
        wr_cfg(32'h0800_0000);
        @(posedge clk);
        internal_access <= 1'b1;
        internal_is_read <= 1'b1;
        internal_addr <= 13'h1abc;
        internal_data <= 32'hdead_beef;
        @(posedge clk);
        internal_access <= 1'b0;
        #1;
        chk(32'({debug_drive_oe, debug_addr, debug_read_n, register_strobe_n}), 32'h0000_eaf0);
        chk(debug_data, 32'hdead_beef);
        @(posedge clk);
        #1;
        chk(32'(register_strobe_n), 32'h0000_0001);
    endtask : t_debug
    task automatic t_comb;
        logic [31:0] cf [4] = '{32'h0557_000a, 32'h02a6_0004, 32'h0006_0000, 32'h0003_0000};
        foreach (cf[i])
        begin
            wr_cfg(cf[i]);
            @(posedge clk);
            {remap_two_hit, remap_one_hit, write_in_page, user_mode, bank_space} <= 5'h1e;
            static_decode <= 3'h7;
            bank_addr_sel <= 2'(i % 2);
            #1;
            chk(32'({remap_two_active, remap_one_active, hold_page}), 32'(cf[i][26:24]));
            chk(32'(static_sel_en), 32'({cf[i][23:21], 1'b0}));
            chk(32'(static_wide[3:1]), 32'(cf[i][3:1]));
            chk(32'({bank_type, bank_is_sdram}), 32'({cf[i][17 + 2 * (i % 2) -: 2], cf[i][17 + 2 * (i % 2)]}));
            @(posedge clk);
            {user_mode, bank_space} <= 2'h1;
            static_decode <= 3'h0;
            #1;
            chk(32'(static_sel_en[1]), 32'(cf[i][20]));
        end
    endtask : t_comb
    task automatic t_mux;
        logic [31:0] cf [5] = '{32'h0000_0000, 32'h0000_3000, 32'h0000_0000, 32'h0000_0090, 32'h0000_0050};
        logic [31:0] ex [5] = '{32'h0000_03ff, 32'h0000_1fff, 32'h0000_07ff, 32'h0000_03ff, 32'h0000_09ff};
        foreach (cf[i])
        begin
            wr_cfg(cf[i]);
            @(posedge clk);
            bank_addr_sel <= 2'h0;
            col_phase <= (i >= 2);
            #1;
            chk(32'(mux_addr), ex[i]);
        end
    endtask : t_mux
    task automatic run_acc(input logic rd, input int beats, input int lat, input int fin);
        int n;
        int first;
        int last;
        n = 0;
        first = 0;
        last = 0;
        @(posedge clk);
        acc_start <= 1'b1;
        acc_is_read <= rd;
        acc_burst <= 1'b1;
        @(posedge clk);
        acc_start <= 1'b0;
        for (int t = 1; t < 60; t++)
        begin
            #1;
            if (t == 1)
                chk(32'({acc_page_mode, acc_busy, acc_time_used}), 32'(14 + lat + 32 * (beats > 1)));
            if (acc_done === 1'b1 && n++ == 0)
                first = t;
            if (acc_done === 1'b1)
                last = t;
            @(posedge clk);
        end
        chk(32'(n), 32'(beats));
        chk(32'(first), 32'(lat));
        chk(32'(last), 32'(fin));
    endtask : run_acc
    task automatic t_access;
        wr(memcfg_pkg::OFS_MEMSEL_TIMING, 32'h0000_0032);
        wr(memcfg_pkg::OFS_CARD_TIMING, 32'h0000_1000);
        run_acc(1'b1, 4, 5, 17);
        run_acc(1'b0, 1, 5, 5);
        wr(memcfg_pkg::OFS_CARD_TIMING, 32'h0000_0000);
        wr(memcfg_pkg::OFS_MEMSEL_TIMING, 32'h0000_0055);
        run_acc(1'b1, 1, 7, 7);
    endtask : t_access
    task automatic t_strap;
        test_strap_pin <= 1'b0;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(memcfg_pkg::OFS_BANK_SETUP, 32'h0000_0000);
    endtask : t_strap
    task automatic give_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_clock();
        t_power();
        t_debug();
        t_comb();
        t_mux();
        t_access();
        t_strap();
        give_verdict();
    end
    initial
    begin
        #100000;
        failures++;
        give_verdict();
    end
endmodule : tb_memory_interface_config
